// ==== design/srw_pkg.sv ====
// Package of constants and types for the system reset watchdog
`default_nettype none
package srw_pkg;
	// ------------------------------------------------------------
	// Clock and time bases
	// ------------------------------------------------------------
	localparam int CLK_HZ = 25000000;
	localparam int TICK_MS = 1;
	localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
	localparam int DIV_W = 15;
	localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(TICK_CYCLES - 1);
	localparam logic [DIV_W-1:0] DIV_ZERO = 15'h0000;
	// ------------------------------------------------------------
	// Delay codes
	// ------------------------------------------------------------
	localparam int SEL_W = 5;
	localparam logic [SEL_W-1:0] RST_SEL_MAX = 5'h10;
	localparam logic [SEL_W-1:0] INIT_SEL_MAX = 5'h0F;
	localparam logic [SEL_W-1:0] SEL_OFF = 5'h00;
	localparam int RST_MS_BASE = 1;
	localparam int INIT_MS_BASE = 100;
	localparam int TO_MS_STEP = 10;
	localparam int TO_W = 8;
	localparam int MS_W = 22;
	localparam logic [MS_W-1:0] MS_ZERO = 22'h000000;
	localparam logic [MS_W-1:0] MS_ONE = 22'h000001;
	localparam logic [TO_W-1:0] TO_ZERO = 8'h00;
	localparam int PULSE_MS = 1;
	localparam int RAIL_W = 12;
	typedef enum {
		SRW_ST_WAIT_PG,
		SRW_ST_DELAY,
		SRW_ST_RELEASED
	} srw_seq_type;
	typedef enum {
		SRW_WD_IDLE,
		SRW_WD_INIT,
		SRW_WD_RUN,
		SRW_WD_EXPIRED
	} srw_wd_type;
endpackage : srw_pkg
`default_nettype wire

// ==== design/srw_tick_if.sv ====
// Interface carrying the millisecond tick between block modules
`default_nettype none
interface srw_tick_if;
	logic tick;
	modport src (output tick);
	modport dst (input tick);
endinterface : srw_tick_if
`default_nettype wire

// ==== design/srw_ms_tick.sv ====
// Millisecond tick generator
`default_nettype none
module srw_ms_tick
	import srw_pkg::*;
(
	input wire logic clk,
	input wire logic sys_rst,
	srw_tick_if.src tk
);
	logic [DIV_W-1:0] div;
	// ------------------------------------------------------------
	// Free running divider
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			div <= DIV_ZERO;
			tk.tick <= 1'b0;
		end else begin
			tk.tick <= (div == DIV_LAST);
			div <= (div == DIV_LAST) ? DIV_ZERO : div + DIV_W'(1);
		end
	end
	// Tick lasts one cycle and only follows a divider wrap, so ticks sit one ms apart
	a_tick_spacing: assert property (@(posedge clk) disable iff (sys_rst)
		tk.tick |-> (div == DIV_ZERO) ##1 !tk.tick)
		else $error("tick off the divider wrap");
endmodule : srw_ms_tick
`default_nettype wire

// ==== design/srw_watchdog.sv ====
// System reset sequencing and watchdog timer top
// ------------------------------------------------------------
// How it works
// - Reset output stays asserted until selected rails are good, then a delay.
// - Reset delay code picks 0 ms or 1 ms doubling up to 32.8 s.
// - One kick input, one timeout output; watchdog free or tied to reset release.
// - Host kicks via input toggle or command strobe; either restarts count.
// - Initial wait code: 0, or 100 ms doubling to 1638 s before timing.
// - Timeout period is code times 10 ms, 0 to 2.55 s.
// - On expiry assert timeout output or pulse the reset output, as chosen.
// - Expired state holds until next kick by pin or command, or until wd_enable drops.
// ------------------------------------------------------------
`default_nettype none
module srw_watchdog
	import srw_pkg::*;
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [RAIL_W-1:0] rail_good,
	input wire logic [RAIL_W-1:0] rail_select,
	input wire logic [SEL_W-1:0] reset_delay_sel,
	input wire logic wd_enable,
	input wire logic wd_tied_to_reset,
	input wire logic wd_pulse_mode,
	input wire logic [SEL_W-1:0] wd_init_sel,
	input wire logic [TO_W-1:0] wd_timeout_sel,
	input wire logic watchdog_kick_input,
	input wire logic wd_kick_cmd,
	output logic system_reset_n,
	output logic watchdog_timeout_output,
	output logic wd_expired
);
	srw_tick_if tk ();
	srw_seq_type seq;
	srw_wd_type wd;
	logic [MS_W-1:0] seq_cnt;
	logic [MS_W-1:0] init_cnt;
	logic [TO_W-1:0] to_cnt;
	logic [3:0] to_sub;
	logic kick_q;
	logic kick;
	logic pulse_act;
	logic rails_ok;
	logic [MS_W-1:0] rst_ms;
	logic [MS_W-1:0] init_ms;

	srw_ms_tick u_tick (.clk(clk), .sys_rst(sys_rst), .tk(tk));

	// ------------------------------------------------------------
	// Decode of selectable durations
	// ------------------------------------------------------------
	// All selected rails must be good; empty selection never releases
	assign rails_ok = ((rail_good & rail_select) == rail_select) && (rail_select != '0);
	// Codes above the table clamp to the largest entry
	always_comb begin
		if (reset_delay_sel == SEL_OFF) begin
			rst_ms = MS_ZERO;
		end else if (reset_delay_sel > RST_SEL_MAX) begin
			rst_ms = MS_W'(RST_MS_BASE) << (RST_SEL_MAX - 1'b1);
		end else begin
			rst_ms = MS_W'(RST_MS_BASE) << (reset_delay_sel - 1'b1);
		end
		if (wd_init_sel == SEL_OFF) begin
			init_ms = MS_ZERO;
		end else if (wd_init_sel > INIT_SEL_MAX) begin
			init_ms = MS_W'(INIT_MS_BASE) << (INIT_SEL_MAX - 1'b1);
		end else begin
			init_ms = MS_W'(INIT_MS_BASE) << (wd_init_sel - 1'b1);
		end
	end

	// ------------------------------------------------------------
	// Power-on reset sequencing
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			seq <= SRW_ST_WAIT_PG;
			seq_cnt <= MS_ZERO;
		end else begin
			case (seq)
				SRW_ST_WAIT_PG: begin
					seq_cnt <= MS_ZERO;
					if (rails_ok) begin
						seq <= SRW_ST_DELAY;
					end
				end
				SRW_ST_DELAY: begin
					// Rail dropout restarts the wait
					if (!rails_ok) begin
						seq <= SRW_ST_WAIT_PG;
					end else if (seq_cnt >= rst_ms) begin
						seq <= SRW_ST_RELEASED;
					end else if (tk.tick) begin
						seq_cnt <= seq_cnt + MS_ONE;
					end
				end
				SRW_ST_RELEASED: begin
					if (!rails_ok) begin
						seq <= SRW_ST_WAIT_PG;
					end
				end
				default: seq <= SRW_ST_WAIT_PG;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Kick detection
	// ------------------------------------------------------------
	// Pin treated synchronous; any edge is a kick
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			kick_q <= 1'b0;
		end else begin
			kick_q <= watchdog_kick_input;
		end
	end
	assign kick = (watchdog_kick_input != kick_q) || wd_kick_cmd;

	// ------------------------------------------------------------
	// Watchdog state machine
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			wd <= SRW_WD_IDLE;
			init_cnt <= MS_ZERO;
			to_cnt <= TO_ZERO;
			to_sub <= 4'h0;
		end else begin
			case (wd)
				SRW_WD_IDLE: begin
					init_cnt <= MS_ZERO;
					// Tied mode waits for reset release
					if (wd_enable && (!wd_tied_to_reset || seq == SRW_ST_RELEASED)) begin
						wd <= SRW_WD_INIT;
					end
				end
				SRW_WD_INIT: begin
					if (!wd_enable) begin
						wd <= SRW_WD_IDLE;
					end else if (init_cnt >= init_ms) begin
						wd <= SRW_WD_RUN;
						to_cnt <= wd_timeout_sel;
						to_sub <= 4'h0;
					end else if (tk.tick) begin
						init_cnt <= init_cnt + MS_ONE;
					end
				end
				SRW_WD_RUN: begin
					if (!wd_enable) begin
						wd <= SRW_WD_IDLE;
					end else if (kick) begin
						to_cnt <= wd_timeout_sel;
						to_sub <= 4'h0;
					end else if (to_cnt == TO_ZERO) begin
						wd <= SRW_WD_EXPIRED;
					end else if (tk.tick) begin
						// Ten ms per timeout step
						if (to_sub == 4'(TO_MS_STEP - 1)) begin
							to_sub <= 4'h0;
							to_cnt <= to_cnt - TO_W'(1);
						end else begin
							to_sub <= to_sub + 4'h1;
						end
					end
				end
				SRW_WD_EXPIRED: begin
					if (!wd_enable) begin
						wd <= SRW_WD_IDLE;
					end else if (kick) begin
						wd <= SRW_WD_RUN;
						to_cnt <= wd_timeout_sel;
						to_sub <= 4'h0;
					end
				end
				default: wd <= SRW_WD_IDLE;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	// Pulse lasts one ms tick window after entering expiry
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			pulse_act <= 1'b0;
		end else if (wd == SRW_WD_RUN && to_cnt == TO_ZERO && !kick && wd_enable
			&& wd_pulse_mode) begin
			pulse_act <= 1'b1;
		end else if (tk.tick) begin
			pulse_act <= 1'b0;
		end
	end
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			system_reset_n <= 1'b0;
			watchdog_timeout_output <= 1'b0;
			wd_expired <= 1'b0;
		end else begin
			system_reset_n <= (seq == SRW_ST_RELEASED) && !pulse_act;
			watchdog_timeout_output <= (wd == SRW_WD_EXPIRED) && !wd_pulse_mode;
			wd_expired <= (wd == SRW_WD_EXPIRED);
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	// Registered release lags the rail sample by two edges, so a drop shows late
	a_reset_needs_rails: assert property (@(posedge clk) disable iff (sys_rst)
		system_reset_n |-> $past(rails_ok, 2))
		else $error("reset released without rails");
	a_zero_delay_release: assert property (@(posedge clk) disable iff (sys_rst)
		(seq == SRW_ST_DELAY && rails_ok && reset_delay_sel == SEL_OFF)
		|=> seq == SRW_ST_RELEASED)
		else $error("zero delay not immediate");
	a_tied_waits: assert property (@(posedge clk) disable iff (sys_rst)
		(wd == SRW_WD_IDLE && wd_tied_to_reset && seq != SRW_ST_RELEASED)
		|=> wd == SRW_WD_IDLE)
		else $error("tied watchdog started early");
	a_kick_reloads: assert property (@(posedge clk) disable iff (sys_rst)
		(wd == SRW_WD_RUN && wd_enable && kick) |=> to_cnt == $past(wd_timeout_sel))
		else $error("kick did not reload");
	a_zero_init_run: assert property (@(posedge clk) disable iff (sys_rst)
		(wd == SRW_WD_INIT && wd_enable && wd_init_sel == SEL_OFF) |=> wd == SRW_WD_RUN)
		else $error("zero init wait not immediate");
	a_timeout_expires: assert property (@(posedge clk) disable iff (sys_rst)
		(wd == SRW_WD_RUN && wd_enable && !kick && to_cnt == TO_ZERO)
		|=> ##1 wd_expired)
		else $error("expiry missed");
	a_timeout_pin_level: assert property (@(posedge clk) disable iff (sys_rst)
		(wd == SRW_WD_EXPIRED && !wd_pulse_mode) |=> watchdog_timeout_output)
		else $error("timeout output not asserted");
	a_expiry_pulses_reset: assert property (@(posedge clk) disable iff (sys_rst)
		(wd == SRW_WD_RUN && wd_enable && !kick && to_cnt == TO_ZERO && wd_pulse_mode)
		|=> ##1 !system_reset_n)
		else $error("expiry gave no reset pulse");
	a_expired_holds: assert property (@(posedge clk) disable iff (sys_rst)
		(wd == SRW_WD_EXPIRED && wd_enable && !kick) |=> wd == SRW_WD_EXPIRED)
		else $error("expiry left without kick");
	a_edge_is_kick: assert property (@(posedge clk) disable iff (sys_rst)
		(wd == SRW_WD_EXPIRED && wd_enable && $changed(watchdog_kick_input))
		|=> wd == SRW_WD_RUN)
		else $error("pin edge ignored");
	c_release: cover property (@(posedge clk) $rose(system_reset_n));
	c_expiry: cover property (@(posedge clk) $rose(wd_expired));
	c_pulse: cover property (@(posedge clk) $rose(pulse_act));
	c_restart: cover property (@(posedge clk) $fell(wd_expired));
endmodule : srw_watchdog
`default_nettype wire

// ==== bench/srw_host.sv ====
// Host model that kicks the watchdog by pin toggle or command pulse
`default_nettype none
module srw_host (
	input wire logic clk,
	input wire logic pin_req,
	input wire logic cmd_req,
	output logic watchdog_kick_input,
	output logic wd_kick_cmd
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		watchdog_kick_input = 1'b0;
		wd_kick_cmd = 1'b0;
	end
	// Falling edge launch keeps kicks clear of the sampling edge
	always @(negedge clk) begin
		if (pin_req) watchdog_kick_input <= ~watchdog_kick_input;
		wd_kick_cmd <= cmd_req;
	end
endmodule : srw_host
`default_nettype wire

// ==== bench/tb_system_reset_watchdog.sv ====
// Self-checking bench for the system reset watchdog
`default_nettype none
module tb_system_reset_watchdog
	import srw_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk, sys_rst, wd_enable, wd_tied, wd_pulse, pin_req, cmd_req;
	logic [RAIL_W-1:0] rail_good, rail_select;
	logic [SEL_W-1:0] delay_sel, init_sel;
	logic [TO_W-1:0] to_sel;
	wire logic kick_pin, kick_cmd, system_reset_n, wd_out, wd_expired;
	int fails = 0;
	int total_checks = 0;
	int n;
	srw_watchdog dut (.clk(clk), .sys_rst(sys_rst), .rail_good(rail_good),
		.rail_select(rail_select), .reset_delay_sel(delay_sel), .wd_enable(wd_enable),
		.wd_tied_to_reset(wd_tied), .wd_pulse_mode(wd_pulse), .wd_init_sel(init_sel),
		.wd_timeout_sel(to_sel), .watchdog_kick_input(kick_pin), .wd_kick_cmd(kick_cmd),
		.system_reset_n(system_reset_n), .watchdog_timeout_output(wd_out),
		.wd_expired(wd_expired));
	srw_host host (.clk(clk), .pin_req(pin_req), .cmd_req(cmd_req),
		.watchdog_kick_input(kick_pin), .wd_kick_cmd(kick_cmd));
	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	task cmp(input string m, input logic got, input logic exp);
		total_checks++;
		if (got !== exp) begin
			fails++;
			$display("ERROR %0t %s", $time, m);
		end
	endtask : cmp
	// Bounded wait on reset output (0) or expiry flag (1), counts cycles
	task wait_sig(input int which, input logic v, input int lim, output int k);
		k = 0;
		while (k < lim && (which == 0 ? system_reset_n : wd_expired) !== v) begin
			@(negedge clk);
			k++;
		end
	endtask : wait_sig
	task end_of_test;
		$display("checks %0d fails %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : end_of_test
	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task t_release0;
		repeat (100) @(negedge clk);
		cmp("reset released early", system_reset_n, 1'b0);
		rail_good <= 12'h003;
		wait_sig(0, 1'b1, 6, n);
		cmp("no release with zero delay", system_reset_n, 1'b1);
	endtask : t_release0
	// Two ms code must hold reset between one and two ms of ticks
	task t_delay2;
		rail_good <= 12'h001;
		wait_sig(0, 1'b0, 6, n);
		cmp("rail drop kept reset high", system_reset_n, 1'b0);
		delay_sel <= 5'h02;
		rail_good <= 12'h003;
		wait_sig(0, 1'b1, 50100, n);
		cmp("delay too short", n > 24990, 1'b1);
		cmp("delay too long", n < 50010, 1'b1);
	endtask : t_delay2
	task t_level;
		wd_enable <= 1'b1;
		wait_sig(1, 1'b1, 10, n);
		cmp("no expiry", wd_expired, 1'b1);
		cmp("timeout pin low", wd_out, 1'b1);
		cmp("reset pulsed in level mode", system_reset_n, 1'b1);
		repeat (50) @(negedge clk);
		cmp("expiry cleared alone", wd_expired, 1'b1);
	endtask : t_level
	// Rising pin, falling pin, then command: each must restart the count
	task t_kick;
		for (int i = 0; i < 3; i++) begin
			if (i < 2) pin_req <= 1'b1;
			else cmd_req <= 1'b1;
			@(negedge clk);
			pin_req <= 1'b0;
			cmd_req <= 1'b0;
			wait_sig(1, 1'b0, 6, n);
			cmp("kick ignored", wd_expired, 1'b0);
			wait_sig(1, 1'b1, 10, n);
			cmp("no expiry after kick", wd_expired, 1'b1);
		end
	endtask : t_kick
	task t_pulse;
		wd_enable <= 1'b0;
		wd_pulse <= 1'b1;
		repeat (5) @(negedge clk);
		cmp("disable kept expiry", wd_expired, 1'b0);
		wd_enable <= 1'b1;
		wait_sig(0, 1'b0, 10, n);
		cmp("no reset pulse", system_reset_n, 1'b0);
		cmp("timeout pin in pulse mode", wd_out, 1'b0);
		wait_sig(0, 1'b1, 25010, n);
		cmp("reset pulse stuck", system_reset_n, 1'b1);
	endtask : t_pulse
	// Nonzero timeout holds off expiry; a kick while running reloads the new value
	task t_reload;
		to_sel <= 8'h01;
		pin_req <= 1'b1;
		@(negedge clk);
		pin_req <= 1'b0;
		repeat (20) @(negedge clk);
		cmp("ten ms timeout expired early", wd_expired, 1'b0);
		to_sel <= 8'h00;
		cmd_req <= 1'b1;
		@(negedge clk);
		cmd_req <= 1'b0;
		wait_sig(1, 1'b1, 10, n);
		cmp("run kick did not reload", wd_expired, 1'b1);
	endtask : t_reload
	// Tied watchdog waits for reset release, then honours the initial wait
	task t_tied;
		wd_enable <= 1'b0;
		wd_pulse <= 1'b0;
		wd_tied <= 1'b1;
		delay_sel <= 5'h00;
		rail_good <= 12'h001;
		repeat (5) @(negedge clk);
		wd_enable <= 1'b1;
		repeat (20) @(negedge clk);
		cmp("tied watchdog ran in reset", wd_expired, 1'b0);
		cmp("reset left with rails down", system_reset_n, 1'b0);
		rail_good <= 12'h003;
		wait_sig(1, 1'b1, 10, n);
		cmp("tied watchdog not started", wd_expired, 1'b1);
		cmp("no release after rails", system_reset_n, 1'b1);
		wd_enable <= 1'b0;
		init_sel <= 5'h01;
		repeat (5) @(negedge clk);
		wd_enable <= 1'b1;
		repeat (200) @(negedge clk);
		cmp("initial wait skipped", wd_expired, 1'b0);
	endtask : t_tied
	// ------------------------------------------------------------
	// Main sequence and watchdog
	// ------------------------------------------------------------
	initial begin
		sys_rst = 1'b1;
		{wd_enable, wd_tied, wd_pulse, pin_req, cmd_req} = 5'h00;
		rail_good = 12'h001;
		rail_select = 12'h003;
		{delay_sel, init_sel, to_sel} = 18'h00000;
		repeat (11) @(negedge clk);
		sys_rst <= 1'b0;
		@(negedge clk);
		cmp("reset held outputs", {system_reset_n, wd_out, wd_expired} == 3'b000, 1'b1);
		t_release0();
		t_delay2();
		t_level();
		t_kick();
		t_reload();
		t_pulse();
		t_tied();
		end_of_test();
	end
	// Scenarios need about 75k cycles, mostly waiting on ms ticks; limit adds margin
	initial begin
		#(40 * 90000);
		fails++;
		end_of_test();
	end
endmodule : tb_system_reset_watchdog
`default_nettype wire
